//--- fasp_pkg.sv
// constants, register map and carrier types for the fifo serial port
// assumes a single 250 MHz clock and a simple strobe register port
// Notes on behaviour
// - overrun flag at bit 0, write clears only
// - overrun clears on reset or read-then-write-zero
// - overrun sets when full fifo receives another
// - receive disable leaves overrun flag unchanged
// - overrun keeps stored data, drops new ones
// - no storing while overrun flag is set
// - line status bits 15..1 read zero
// - sixteen-entry transmit and receive fifos
// - asynchronous only, resync on start bit
// - mode bit 6 selects 8 or 7 bits
// - bit 5 parity enable, bit 3 stops
// - eight formats, at most twelve bit periods
// - detect framing, parity, full, overrun, ready, break
// - report transmit and receive fifo counts
// - control bit 1 selects external clock
// - internal baud generator gives 16x clock
// - serial clock pin unused when internal
// - request-to-send output, clear-to-send input
// - data bits least significant first
// - start bit low, stop bits high
// - only first stop bit checked
package fasp_pkg;
  localparam int ADDR_W = 4;
  localparam logic [3:0] OFS_MODE    = 4'h0;
  localparam logic [3:0] OFS_CTRL    = 4'h1;
  localparam logic [3:0] OFS_BAUD    = 4'h2;
  localparam logic [3:0] OFS_TXDATA  = 4'h3;
  localparam logic [3:0] OFS_STATUS  = 4'h4;
  localparam logic [3:0] OFS_RXDATA  = 4'h5;
  localparam logic [3:0] OFS_COUNT   = 4'h6;
  localparam logic [3:0] OFS_LINE    = 4'h7;
  localparam int MODE_ODD_BIT   = 4;
  localparam int MODE_STOP_BIT  = 3;
  localparam int MODE_PAR_BIT   = 5;
  localparam int MODE_CHR_BIT   = 6;
  localparam int CTRL_CKSRC_BIT = 1;
  localparam int CTRL_RE_BIT    = 4;
  localparam int CTRL_TE_BIT    = 5;
  localparam int LINE_ORUN_BIT  = 0;
  localparam logic [15:0] MODE_RST = 16'h0000;
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [15:0] BAUD_RST = 16'h0000;
  localparam logic [15:0] LINE_RST = 16'h0000;
  localparam int OVERSAMPLE = 16;
  localparam logic [3:0] MID_TICK  = 4'h7;
  localparam logic [3:0] LAST_TICK = 4'hf;
  typedef struct packed {
    logic       chr7;
    logic       par_en;
    logic       par_odd;
    logic       stop2;
  } fasp_fmt_type;
  typedef struct packed {
    logic       ferr;
    logic       perr;
    logic       brk;
    logic [7:0] data;
  } fasp_rxword_type;
  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_START = 4'b0010,
    ST_BITS  = 4'b0100,
    ST_STOP  = 4'b1000
  } fasp_state_type;
endpackage : fasp_pkg

//--- fasp_remote.sv
// remote serial device: drives frames into the port, checks frames out of it
// assumes the bench calls send and recv by name and sets bit_ns to match the tick rate
`timescale 1ns/1ps
module fasp_remote (
  output logic      rx_line,
  input  wire logic tx_line,
  output logic      sclk,
  output logic      cts_n
);
  import fasp_pkg::*;
  realtime bit_ns;
  initial begin
    rx_line = 1'b1;
    cts_n   = 1'b0;
    sclk    = 1'b0;
    bit_ns  = 64.0;
  end
  // free running: an external clock may never stop, and in internal mode it must be ignored
  always #8 sclk = ~sclk;

  // bad[0] flips parity, bad[1] lowers the first stop, bad[2] the second
  task automatic send(input fasp_fmt_type f, input logic [7:0] d, input logic [2:0] bad);
    logic q[$];
    logic p;
    p = (f.chr7 ? ^d[6:0] : ^d) ^ f.par_odd ^ bad[0];
    q.push_back(1'b0);
    for (int i = 0; i < (f.chr7 ? 7 : 8); i++) q.push_back(d[i]);
    if (f.par_en) q.push_back(p);
    q.push_back(~bad[1]);
    if (f.stop2) q.push_back(~bad[2]);
    q.push_back(1'b1);
    foreach (q[k]) begin
      rx_line = q[k];
      #(bit_ns);
    end
  endtask : send

  // returns in the middle of the last stop bit
  task automatic recv(input fasp_fmt_type f, output logic [7:0] d, output logic p, output logic ok);
    int w;
    w = 0;
    d = 8'h00;
    p = 1'b0;
    while (tx_line !== 1'b0 && w < 20000) begin
      #1;
      w++;
    end
    #(bit_ns / 2);
    ok = (w < 20000) && (tx_line === 1'b0);
    for (int i = 0; i < (f.chr7 ? 7 : 8); i++) begin
      #(bit_ns);
      d[i] = tx_line;
    end
    if (f.par_en) begin
      #(bit_ns);
      p = tx_line;
    end
    #(bit_ns);
    ok = ok && (tx_line === 1'b1);
    if (f.stop2) begin
      #(bit_ns);
      ok = ok && (tx_line === 1'b1);
    end
  endtask : recv
endmodule : fasp_remote

//--- fasp_top.sv
// fifo serial port: transmitter, receiver, two fifos, register file
// assumes rx, cts and serial clock pins are asynchronous to clk
`timescale 1ns/1ps
module fasp_top #(
  parameter int DEPTH = 16
) (
  input  wire logic                       clk,
  input  wire logic                       resetn,
  input  wire logic [fasp_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [15:0]                reg_wdata,
  input  wire logic                       reg_wr,
  input  wire logic                       reg_rd,
  output logic      [15:0]                reg_rdata,
  input  wire logic                       rx_pin,
  output logic                            tx_pin,
  input  wire logic                       serial_clock_pin,
  output logic                            request_to_send_out_n,
  input  wire logic                       clear_to_send_in_n
);
  import fasp_pkg::*;
  localparam int CW = $clog2(DEPTH + 1);
  localparam int PW = $clog2(DEPTH);

  logic [15:0] mode_q, ctrl_q, baud_q;
  logic        overrun_flag_q, orun_seen_q;
  logic [15:0] rdata_q;
  fasp_fmt_type fmt;
  assign fmt = '{chr7: mode_q[MODE_CHR_BIT], par_en: mode_q[MODE_PAR_BIT],
                 par_odd: mode_q[MODE_ODD_BIT], stop2: mode_q[MODE_STOP_BIT]};

  function automatic logic wr_hit(input logic [3:0] a, input logic [3:0] o, input logic w);
    wr_hit = w && (a == o);
  endfunction : wr_hit

  // three-stage synchronisers, change accepted when stages 2 and 3 agree
  logic [2:0] rx_s, cts_s, sck_s;
  logic       rx_f, cts_f, sck_f;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rx_s  <= 3'h7;
      cts_s <= 3'h7;
      sck_s <= 3'h0;
    end else begin
      rx_s  <= {rx_s[1:0], rx_pin};
      cts_s <= {cts_s[1:0], clear_to_send_in_n};
      sck_s <= {sck_s[1:0], serial_clock_pin};
    end
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rx_f  <= 1'b1;
      cts_f <= 1'b1;
      sck_f <= 1'b0;
    end else begin
      if (rx_s[1] == rx_s[2]) rx_f <= rx_s[2];
      if (cts_s[1] == cts_s[2]) cts_f <= cts_s[2];
      if (sck_s[1] == sck_s[2]) sck_f <= sck_s[2];
    end
  end

  // 16x tick: internal divider or rising edge of external clock
  logic [15:0] bdiv_q;
  logic        sck_prev_q, tick;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      bdiv_q     <= 16'h0000;
      sck_prev_q <= 1'b0;
    end else begin
      sck_prev_q <= sck_f;
      if (bdiv_q >= baud_q) bdiv_q <= 16'h0000;
      else bdiv_q <= bdiv_q + 16'h0001;
    end
  end
  assign tick = ctrl_q[CTRL_CKSRC_BIT] ? (sck_f && !sck_prev_q)
                                       : (bdiv_q >= baud_q);

  // fifos: sixteen entries each
  logic [7:0]            tx_mem [DEPTH];
  fasp_rxword_type       rx_mem [DEPTH];
  logic [PW-1:0]         tx_wp, tx_rp, rx_wp, rx_rp;
  logic [CW-1:0]         tx_cnt, rx_cnt;
  logic                  tx_push, tx_pop, rx_push, rx_pop;
  fasp_rxword_type       rx_word;
  assign tx_push = wr_hit(reg_addr, OFS_TXDATA, reg_wr) && (tx_cnt != CW'(DEPTH));
  assign rx_pop  = reg_rd && (reg_addr == OFS_RXDATA) && (rx_cnt != '0);
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tx_wp  <= '0;
      tx_rp  <= '0;
      tx_cnt <= '0;
    end else begin
      if (tx_push) tx_wp <= tx_wp + 1'b1;
      if (tx_pop) tx_rp <= tx_rp + 1'b1;
      tx_cnt <= tx_cnt + CW'(tx_push) - CW'(tx_pop);
    end
  end
  always_ff @(posedge clk) begin
    if (tx_push) tx_mem[tx_wp] <= reg_wdata[7:0];
    if (rx_push) rx_mem[rx_wp] <= rx_word;
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rx_wp  <= '0;
      rx_rp  <= '0;
      rx_cnt <= '0;
    end else begin
      if (rx_push) rx_wp <= rx_wp + 1'b1;
      if (rx_pop) rx_rp <= rx_rp + 1'b1;
      rx_cnt <= rx_cnt + CW'(rx_push) - CW'(rx_pop);
    end
  end

  // transmitter
  fasp_state_type tx_st;
  logic [3:0]  tx_sub;
  logic [3:0]  tx_nbit, tx_idx;
  logic [9:0]  tx_sh;
  logic        tx_q;
  logic [3:0]  data_len;
  assign data_len = fmt.chr7 ? 4'h7 : 4'h8;
  assign tx_pop = (tx_st == ST_IDLE) && ctrl_q[CTRL_TE_BIT] && (tx_cnt != '0) && !cts_f;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tx_st   <= ST_IDLE;
      tx_sub  <= 4'h0;
      tx_idx  <= 4'h0;
      tx_nbit <= 4'h0;
      tx_sh   <= 10'h000;
      tx_q    <= 1'b1;
    end else if (!ctrl_q[CTRL_TE_BIT]) begin
      tx_st <= ST_IDLE;
      tx_q  <= 1'b1;
    end else begin
      case (tx_st)
        ST_IDLE: begin
          tx_q <= 1'b1;
          if (tx_pop) begin
            // data lsb first, then parity, then stop ones
            tx_sh   <= fmt.chr7 ? {2'b11, fmt.par_odd ^ (^tx_mem[tx_rp][6:0]), tx_mem[tx_rp][6:0]}
                                : {1'b1, fmt.par_odd ^ (^tx_mem[tx_rp]), tx_mem[tx_rp]};
            tx_nbit <= data_len + (fmt.par_en ? 4'h1 : 4'h0);
            tx_sub  <= 4'h0;
            tx_st   <= ST_START;
          end
        end
        ST_START: begin
          tx_q <= 1'b0;
          if (tick) begin
            tx_sub <= tx_sub + 4'h1;
            if (tx_sub == LAST_TICK) begin
              tx_idx <= 4'h0;
              tx_st  <= ST_BITS;
            end
          end
        end
        ST_BITS: begin
          tx_q <= tx_sh[tx_idx];
          if (tick) begin
            tx_sub <= tx_sub + 4'h1;
            if (tx_sub == LAST_TICK) begin
              tx_idx <= tx_idx + 4'h1;
              if (tx_idx == tx_nbit - 4'h1) begin
                tx_idx <= fmt.stop2 ? 4'h1 : 4'h0;
                tx_st  <= ST_STOP;
              end
            end
          end
        end
        ST_STOP: begin
          tx_q <= 1'b1;
          if (tick) begin
            tx_sub <= tx_sub + 4'h1;
            if (tx_sub == LAST_TICK) begin
              tx_idx <= tx_idx - 4'h1;
              if (tx_idx == 4'h0) tx_st <= ST_IDLE;
            end
          end
        end
        default: tx_st <= ST_IDLE;
      endcase
    end
  end
  assign tx_pin = tx_q;

  // receiver: resync on every start edge, sample mid-bit
  fasp_state_type rx_st;
  logic [3:0]  rx_sub, rx_idx, rx_nbit;
  logic [8:0]  rx_sh;
  logic        rx_done;
  logic        rx_par;
  logic        rx_ferr, rx_perr, rx_brk;
  logic        rx_en;
  assign rx_en = ctrl_q[CTRL_RE_BIT];
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rx_st   <= ST_IDLE;
      rx_sub  <= 4'h0;
      rx_idx  <= 4'h0;
      rx_nbit <= 4'h0;
      rx_sh   <= 9'h000;
      rx_done <= 1'b0;
      rx_ferr <= 1'b0;
    end else begin
      rx_done <= 1'b0;
      if (!rx_en) begin
        rx_st <= ST_IDLE;
      end else begin
        case (rx_st)
          ST_IDLE: begin
            if (!rx_f) begin
              rx_sub  <= 4'h0;
              rx_sh   <= 9'h000; // bits a short frame leaves unused must not mask a break
              rx_nbit <= data_len + (fmt.par_en ? 4'h1 : 4'h0);
              rx_st   <= ST_START;
            end
          end
          ST_START: begin
            if (tick) begin
              rx_sub <= rx_sub + 4'h1;
              if (rx_sub == MID_TICK && rx_f) rx_st <= ST_IDLE;
              if (rx_sub == LAST_TICK) begin
                rx_idx <= 4'h0;
                rx_st  <= ST_BITS;
              end
            end
          end
          ST_BITS: begin
            if (tick) begin
              rx_sub <= rx_sub + 4'h1;
              if (rx_sub == MID_TICK) rx_sh[rx_idx] <= rx_f;
              if (rx_sub == LAST_TICK) begin
                rx_idx <= rx_idx + 4'h1;
                if (rx_idx == rx_nbit - 4'h1) rx_st <= ST_STOP;
              end
            end
          end
          ST_STOP: begin
            // only the first stop bit is looked at; a second is just idle
            if (tick) begin
              rx_sub <= rx_sub + 4'h1;
              if (rx_sub == MID_TICK) begin
                rx_ferr <= !rx_f;
                rx_done <= 1'b1;
                rx_st   <= ST_IDLE;
              end
            end
          end
          default: rx_st <= ST_IDLE;
        endcase
      end
    end
  end
  assign rx_par  = fmt.chr7 ? rx_sh[7] : rx_sh[8];
  assign rx_perr = fmt.par_en &&
                   (rx_par != (fmt.par_odd ^ (fmt.chr7 ? ^rx_sh[6:0] : ^rx_sh[7:0])));
  assign rx_brk  = rx_ferr && (rx_sh == 9'h000);
  assign rx_word = '{ferr: rx_ferr, perr: rx_perr, brk: rx_brk,
                     data: fmt.chr7 ? {1'b0, rx_sh[6:0]} : rx_sh[7:0]};
  assign rx_push = rx_done && !overrun_flag_q && (rx_cnt != CW'(DEPTH));

  // sticky status from receiver events; set wins over clear
  logic ferr_q, perr_q, brk_q;
  logic st_clr;
  assign st_clr = wr_hit(reg_addr, OFS_STATUS, reg_wr);
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ferr_q <= 1'b0;
      perr_q <= 1'b0;
      brk_q  <= 1'b0;
    end else begin
      ferr_q <= (rx_done && rx_ferr) || (ferr_q && !(st_clr && !reg_wdata[0]));
      perr_q <= (rx_done && rx_perr) || (perr_q && !(st_clr && !reg_wdata[1]));
      brk_q  <= (rx_done && rx_brk) || (brk_q && !(st_clr && !reg_wdata[2]));
    end
  end

  // overrun: independent of receive enable, cleared only after seen as one
  logic orun_set, orun_clr;
  assign orun_set = rx_done && (rx_cnt == CW'(DEPTH));
  assign orun_clr = wr_hit(reg_addr, OFS_LINE, reg_wr) && !reg_wdata[LINE_ORUN_BIT] && orun_seen_q;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      overrun_flag_q <= LINE_RST[LINE_ORUN_BIT];
      orun_seen_q    <= 1'b0;
    end else begin
      if (orun_set) overrun_flag_q <= 1'b1;
      else if (orun_clr) overrun_flag_q <= 1'b0;
      if (orun_clr && !orun_set) orun_seen_q <= 1'b0;
      else if (reg_rd && reg_addr == OFS_LINE && overrun_flag_q) orun_seen_q <= 1'b1;
    end
  end

  // config registers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mode_q <= MODE_RST;
      ctrl_q <= CTRL_RST;
      baud_q <= BAUD_RST;
    end else begin
      if (wr_hit(reg_addr, OFS_MODE, reg_wr)) mode_q <= reg_wdata;
      if (wr_hit(reg_addr, OFS_CTRL, reg_wr)) ctrl_q <= reg_wdata;
      if (wr_hit(reg_addr, OFS_BAUD, reg_wr)) baud_q <= reg_wdata;
    end
  end

  // read data stands only in the cycle after the strobe
  fasp_rxword_type rx_head;
  assign rx_head = rx_mem[rx_rp];
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdata_q <= 16'h0000;
    end else if (!reg_rd) begin
      rdata_q <= 16'h0000;
    end else begin
      case (reg_addr)
        OFS_MODE:   rdata_q <= mode_q;
        OFS_CTRL:   rdata_q <= ctrl_q;
        OFS_BAUD:   rdata_q <= baud_q;
        OFS_STATUS: rdata_q <= {12'h000, rx_cnt != '0, brk_q, perr_q, ferr_q};
        OFS_RXDATA: rdata_q <= (rx_cnt != '0) ? {5'h00, rx_head.brk, rx_head.perr, rx_head.ferr, rx_head.data}
                                              : 16'h0000;
        OFS_COUNT:  rdata_q <= {3'h0, 5'(tx_cnt), 3'h0, 5'(rx_cnt)};
        OFS_LINE:   rdata_q <= {15'h0000, overrun_flag_q};
        default:    rdata_q <= 16'h0000;
      endcase
    end
  end
  assign reg_rdata = rdata_q;

  // rts low means room to receive; high when disabled or nearly full
  assign request_to_send_out_n = !rx_en || (rx_cnt >= CW'(DEPTH - 1));

  AST_ORUN_STICKY: assert property (@(posedge clk) disable iff (!resetn)
    overrun_flag_q && !(reg_wr && reg_addr == OFS_LINE) |=> overrun_flag_q)
    else $error("overrun flag dropped without write");
  AST_ORUN_SEEN: assert property (@(posedge clk) disable iff (!resetn)
    $fell(overrun_flag_q) |-> $past(orun_seen_q))
    else $error("overrun cleared before being read");
  AST_ORUN_SET: assert property (@(posedge clk) disable iff (!resetn)
    rx_done && rx_cnt == CW'(DEPTH) |=> overrun_flag_q)
    else $error("overrun not set on full fifo");
  AST_RE_KEEP: assert property (@(posedge clk) disable iff (!resetn)
    $fell(rx_en) && !orun_clr |=> overrun_flag_q == $past(overrun_flag_q))
    else $error("receive disable changed overrun");
  AST_NO_PUSH: assert property (@(posedge clk) disable iff (!resetn)
    overrun_flag_q |-> !rx_push)
    else $error("stored while overrun set");
  AST_KEEP_CNT: assert property (@(posedge clk) disable iff (!resetn)
    overrun_flag_q && !rx_pop |=> rx_cnt == $past(rx_cnt))
    else $error("fifo changed during overrun");
  AST_CNT_MAX: assert property (@(posedge clk) disable iff (!resetn)
    tx_cnt <= CW'(DEPTH) && rx_cnt <= CW'(DEPTH))
    else $error("fifo count above depth");
  AST_LINE_RD: assert property (@(posedge clk) disable iff (!resetn)
    reg_rd && reg_addr == OFS_LINE |=> reg_rdata[15:1] == 15'h0000 && reg_rdata[0] == $past(overrun_flag_q))
    else $error("line status read wrong");
  AST_START_LOW: assert property (@(posedge clk) disable iff (!resetn)
    tx_st == ST_START ##1 tx_st == ST_START |-> !tx_pin)
    else $error("start bit not low");
  AST_EXT_CLK: assert property (@(posedge clk) disable iff (!resetn)
    !ctrl_q[CTRL_CKSRC_BIT] && $changed(sck_f) |-> tick == (bdiv_q >= baud_q))
    else $error("serial clock pin used while internal");
endmodule : fasp_top

//--- tb_top.sv
// self-checking bench for the fifo serial port
// assumes baud divisor 0, so one bit is 16 clocks of 4 ns
`timescale 1ns/1ps
module tb_top;
  import fasp_pkg::*;
  logic         clk, resetn, reg_wr, reg_rd, rx_pin, tx_pin, sclk, rts_n, cts_n;
  logic [3:0]   reg_addr;
  logic [15:0]  reg_wdata, reg_rdata;
  int           bad_count, n_checks, cyc;
  fasp_fmt_type f;
  logic [7:0]   g, m, d;
  logic         p, ok, held;

  fasp_top #(.DEPTH(16)) u_fasp_top (.clk(clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .rx_pin(rx_pin), .tx_pin(tx_pin), .serial_clock_pin(sclk),
    .request_to_send_out_n(rts_n), .clear_to_send_in_n(cts_n));
  fasp_remote u_fasp_remote (.rx_line(rx_pin), .tx_line(tx_pin), .sclk(sclk), .cts_n(cts_n));

  initial clk = 1'b0;
  always #2 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      bad_count++;
      $display("Error at %0t: run too long", $time);
      end_sim();
    end
  end

  task automatic end_sim;
    $display("checks %0d errors %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_sim

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  // data stand in the cycle after the strobe; sampled at the edge that ends it
  task automatic rdchk(input logic [3:0] a, input logic [15:0] exp, input string what);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    chk(reg_rdata, exp, what);
  endtask : rdchk

  task automatic t_reset;
    rdchk(OFS_LINE, 16'h0000, "line status after reset");
    rdchk(OFS_COUNT, 16'h0000, "counts after reset");
    rdchk(4'h9, 16'h0000, "unmapped read");
    wr(OFS_LINE, 16'hffff);
    rdchk(OFS_LINE, 16'h0000, "line status after writing ones");
    chk({14'h0, rts_n, tx_pin}, 16'h0003, "idle pins");
  endtask : t_reset

  task automatic t_formats;
    for (int i = 0; i < 8; i++) begin
      f = '{chr7: i[2], par_en: i[1], par_odd: i[0] ^ i[2], stop2: i[0]};
      d = 8'h3c + 8'(i * 41);
      m = f.chr7 ? 8'h7f : 8'hff;
      wr(OFS_CTRL, 16'h0000);
      wr(OFS_MODE, {9'h0, f.chr7, f.par_en, f.par_odd, f.stop2, 3'h0});
      wr(OFS_CTRL, 16'h0030);
      wr(OFS_TXDATA, {8'h0, d});
      u_fasp_remote.recv(f, g, p, ok);
      chk({8'h0, g}, {8'h0, d & m}, "tx data");
      chk({14'h0, ok, p}, {14'h0, 1'b1, f.par_en & (^(d & m) ^ f.par_odd)}, "tx frame");
      u_fasp_remote.send(f, ~d, 3'h0);
      rdchk(OFS_RXDATA, {8'h0, ~d & m}, "rx data");
    end
  endtask : t_formats

  task automatic t_errors;
    f = '{chr7: 1'b0, par_en: 1'b1, par_odd: 1'b0, stop2: 1'b1};
    wr(OFS_CTRL, 16'h0000);
    wr(OFS_MODE, 16'h0028);
    wr(OFS_CTRL, 16'h0010);
    u_fasp_remote.send(f, 8'h81, 3'b100);
    rdchk(OFS_RXDATA, 16'h0081, "second stop ignored");
    // a low second stop looks like a start bit; that frame reads idle ones, so parity fails
    repeat (160) @(posedge clk);
    rdchk(OFS_RXDATA, 16'h02ff, "low second stop starts a frame");
    u_fasp_remote.send(f, 8'h42, 3'b001);
    rdchk(OFS_RXDATA, 16'h0242, "parity error");
    u_fasp_remote.send(f, 8'h24, 3'b010);
    rdchk(OFS_RXDATA, 16'h0124, "framing error");
    u_fasp_remote.send(f, 8'h00, 3'b010);
    rdchk(OFS_RXDATA, 16'h0500, "break");
    wr(OFS_STATUS, 16'h0000);
  endtask : t_errors

  task automatic t_overrun;
    f = '0;
    wr(OFS_CTRL, 16'h0000);
    wr(OFS_MODE, 16'h0000);
    wr(OFS_CTRL, 16'h0010);
    @(posedge clk);
    chk({15'h0, rts_n}, 16'h0000, "rts with room");
    for (int i = 0; i < 16; i++) u_fasp_remote.send(f, 8'(i), 3'h0);
    rdchk(OFS_COUNT, 16'h0010, "rx count full");
    chk({15'h0, rts_n}, 16'h0001, "rts when full");
    rdchk(OFS_LINE, 16'h0000, "no overrun at full");
    u_fasp_remote.send(f, 8'haa, 3'h0);
    rdchk(OFS_LINE, 16'h0001, "overrun set");
    wr(OFS_CTRL, 16'h0000);
    rdchk(OFS_LINE, 16'h0001, "overrun kept with receiver off");
    wr(OFS_CTRL, 16'h0010);
    rdchk(OFS_RXDATA, 16'h0000, "oldest kept");
    u_fasp_remote.send(f, 8'hee, 3'h0);
    rdchk(OFS_COUNT, 16'h000f, "no store while overrun");
    rdchk(OFS_LINE, 16'h0001, "overrun still set");
    wr(OFS_LINE, 16'h0000);
    rdchk(OFS_LINE, 16'h0000, "overrun cleared");
    u_fasp_remote.send(f, 8'h77, 3'h0);
    for (int i = 1; i < 16; i++) rdchk(OFS_RXDATA, 16'(i), "kept data");
    rdchk(OFS_RXDATA, 16'h0077, "reception resumed");
    rdchk(OFS_COUNT, 16'h0000, "rx drained");
  endtask : t_overrun

  task automatic t_txfifo;
    wr(OFS_CTRL, 16'h0000);
    for (int i = 0; i < 17; i++) wr(OFS_TXDATA, 16'h0040 + 16'(i));
    rdchk(OFS_COUNT, 16'h1000, "tx count full");
    wr(OFS_CTRL, 16'h0020);
    for (int i = 0; i < 16; i++) begin
      u_fasp_remote.recv(f, g, p, ok);
      chk({7'h0, ok, g}, 16'h0140 + 16'(i), "tx fifo order");
    end
    rdchk(OFS_COUNT, 16'h0000, "tx drained");
  endtask : t_txfifo

  task automatic t_cts;
    held = 1'b1;
    u_fasp_remote.cts_n = 1'b1;
    // let the pin pass its synchroniser and the last frame finish before data arrive
    repeat (8) @(posedge clk);
    wr(OFS_TXDATA, 16'h0096);
    repeat (64) begin
      @(posedge clk);
      if (tx_pin !== 1'b1) held = 1'b0;
    end
    chk({15'h0, held}, 16'h0001, "tx held by clear to send");
    u_fasp_remote.cts_n = 1'b0;
    u_fasp_remote.recv(f, g, p, ok);
    chk({7'h0, ok, g}, 16'h0196, "tx after clear to send");
  endtask : t_cts

  // divisor 1: a tick every second clock, so a 128 ns bit
  task automatic t_baud;
    wr(OFS_CTRL, 16'h0000);
    wr(OFS_BAUD, 16'h0001);
    rdchk(OFS_BAUD, 16'h0001, "baud divisor readback");
    wr(OFS_CTRL, 16'h0030);
    u_fasp_remote.bit_ns = 128.0;
    u_fasp_remote.send(f, 8'h69, 3'h0);
    rdchk(OFS_RXDATA, 16'h0069, "rx on divided clock");
    wr(OFS_TXDATA, 16'h00e1);
    u_fasp_remote.recv(f, g, p, ok);
    chk({7'h0, ok, g}, 16'h01e1, "tx on divided clock");
  endtask : t_baud

  // 16 ns external ticks give a 256 ns bit
  task automatic t_ext;
    wr(OFS_CTRL, 16'h0000);
    wr(OFS_CTRL, 16'h0032);
    u_fasp_remote.bit_ns = 256.0;
    u_fasp_remote.send(f, 8'h5a, 3'h0);
    rdchk(OFS_RXDATA, 16'h005a, "rx on external clock");
    wr(OFS_TXDATA, 16'h00c3);
    u_fasp_remote.recv(f, g, p, ok);
    chk({7'h0, ok, g}, 16'h01c3, "tx on external clock");
  endtask : t_ext

  initial begin
    resetn    = 1'b0;
    reg_addr  = 4'h0;
    reg_wdata = 16'h0000;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    bad_count = 0;
    n_checks  = 0;
    cyc       = 0;
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    t_reset();
    t_formats();
    t_errors();
    t_overrun();
    t_txfifo();
    t_cts();
    t_baud();
    t_ext();
    end_sim();
  end
endmodule : tb_top
